// >>> shared/vihc_consts.vh
`ifndef VIHC_CONSTS_VH
`define VIHC_CONSTS_VH

// System register encodings {op0, op1, crn, crm, op2}, crn held at 5 bits
`define VIHC_ENC_W 17
`define VIHC_ENC_AP1R 17'h1_89c8
`define VIHC_ENC_HCR 17'h1_c658
`define VIHC_ENC_VTR 17'h1_c659
`define VIHC_ENC_VMCR 17'h1_c65f

// Guest view selectors
`define VIHC_G_PMR 3'h0
`define VIHC_G_BP0 3'h1
`define VIHC_G_BP1 3'h2
`define VIHC_G_CTLR 3'h3
`define VIHC_G_EN0 3'h4
`define VIHC_G_EN1 3'h5
`define VIHC_G_DIR 3'h6

// Control register fields
`define VIHC_HCR_CNT_HI 31
`define VIHC_HCR_CNT_LO 27
`define VIHC_HCR_TRAP_DEACTIVATE_WRITES 14
`define VIHC_HCR_TRAP_LOCAL_ERROR_IRQS 13
`define VIHC_HCR_TRAP_GRP1_ACCESSES 12
`define VIHC_HCR_TRAP_GRP0_ACCESSES 11
`define VIHC_HCR_TC 10
`define VIHC_HCR_G1OFF 7
`define VIHC_HCR_G1ON 6
`define VIHC_HCR_G0OFF 5
`define VIHC_HCR_G0ON 4
`define VIHC_HCR_MAINT_ON_NOTHING_PENDING 3
`define VIHC_HCR_LRENP 2
`define VIHC_HCR_UIE 1
`define VIHC_HCR_EN 0
`define VIHC_HCR_RW_MASK 32'h0000_7cff

// VM control register fields
`define VIHC_VM_PMR_HI 31
`define VIHC_VM_PMR_LO 24
`define VIHC_VM_BP0_HI 23
`define VIHC_VM_BP0_LO 21
`define VIHC_VM_BP1_HI 20
`define VIHC_VM_BP1_LO 18
`define VIHC_VM_EOIM 9
`define VIHC_VM_CBPR 4
`define VIHC_VM_FIQ 3
`define VIHC_VM_ENG1 1
`define VIHC_VM_ENG0 0

// Reset values and limits
`define VIHC_AP1R_RST 32'h0000_0000
`define VIHC_HCR_RST 32'h0000_0000
`define VIHC_PMR_RST 8'h00
`define VIHC_BP0_MIN 3'h2
`define VIHC_BP1_MIN 3'h3
`define VIHC_BP_MAX 3'h7
`define VIHC_CNT_MAX 5'h1f

// Fixed type register and guest control read values
`define VIHC_VTR_VAL 32'h9028_0003
`define VIHC_CTLR_RO 32'h0000_8400
`define VIHC_LR_LAST 4'h3

`endif

// >>> src/vihc_bp_field.v
`timescale 1ns/100ps
`default_nettype none

module vihc_bp_field #(
  parameter [2:0] MIN_VALUE = 3'h2
) (
  input wire clock,
  input wire reset,
  input wire ce,
  input wire wr,
  input wire [2:0] wdata,
  output reg [2:0] value
);

  // Values under the floor are raised so the field never holds them
  always @(posedge clock) begin
    if (reset) begin
      value <= MIN_VALUE;
    end else if (ce && wr) begin
      value <= (wdata < MIN_VALUE) ? MIN_VALUE : wdata;
    end
  end

endmodule

`default_nettype wire

// >>> src/vihc_top.v
// Contract
// R1: Bit n marks active priority n times 8
// R2: Active-priority map resets to all zeros
// R3: Control bits 31:27 hold outstanding deactivate count
// R4: Bit 14 traps EL1 deactivate writes
// R5: Bit 13 fixed zero, errors never trap
// R6: Bit 12 traps EL1 Group 1 accesses
// R7: Bit 11 traps EL1 Group 0 accesses
// R8: Bit 10 traps EL1 shared register accesses
// R9: Bits 7..4 raise maintenance on group enables
// R10: Bit 3 raises maintenance when nothing pending
// R11: Bit 2 raises maintenance while count nonzero
// R12: Bit 1 raises maintenance on zero/one valid entries
// R13: Control bit 0 enables the virtual interface
// R14: VM bits 31:24 alias guest priority mask
// R15: VM bits 23:21 alias Group 0 point, min 2
// R16: VM bits 20:18 alias Group 1 point, min 3
// R17: VM bit 9 selects split end-of-interrupt
// R18: Shared point: Group 1 reads plus one, ignores writes
// R19: VM bit 3 fixed one, fast Group 0
// R20: VM bits 1,0 enable Group 1, Group 0
// R21: Type register reports 4 in 31:29, 28:26
// R22: Type register fixed id, error, affinity fields
// R23: Type reports 4 entries (field value 3); higher index undefined
// R24: Type register read only, others read-write
// R25: Reserved bits read zero, writes ignored
`timescale 1ns/100ps
`default_nettype none
`include "vihc_consts.vh"

module vihc_top #(
  parameter LIST_ENTRIES = 4
) (
  input wire clock,
  input wire reset,
  input wire ce,
  input wire sysreg_valid,
  input wire sysreg_write,
  input wire [1:0] sysreg_op0,
  input wire [2:0] sysreg_op1,
  input wire [4:0] sysreg_crn,
  input wire [3:0] sysreg_crm,
  input wire [2:0] sysreg_op2,
  input wire [31:0] sysreg_wdata,
  output reg sysreg_ack,
  output reg sysreg_undefined,
  output reg [31:0] sysreg_rdata,
  input wire lr_access_valid,
  input wire [3:0] lr_access_index,
  output reg lr_access_undefined,
  input wire guest_valid,
  input wire guest_write,
  input wire guest_ns_el1,
  input wire [2:0] guest_sel,
  input wire [31:0] guest_wdata,
  output reg guest_ack,
  output reg guest_trap,
  output reg [31:0] guest_rdata,
  input wire phys_deactivate_write,
  output reg phys_deactivate_trap,
  input wire prio_activate,
  input wire [7:0] prio_activate_level,
  input wire prio_drop,
  input wire deactivate_miss,
  input wire deactivate_done,
  input wire local_error_irq,
  input wire [LIST_ENTRIES-1:0] lr_valid,
  input wire [LIST_ENTRIES-1:0] lr_pending,
  output reg maint_irq,
  output reg vif_enabled,
  output reg error_irq_trap,
  output reg g0_as_fast_irq,
  output reg guest_split_eoi_mode,
  output reg guest_g0_on,
  output reg guest_g1_on,
  output reg guest_shared_binary_point,
  output reg [7:0] guest_priority_mask,
  output reg [31:0] active_map
);

  reg [31:0] group1_active_priority_map;
  reg [4:0] pending_deactivate_count;
  reg trap_deactivate_writes;
  reg trap_grp1_accesses;
  reg trap_grp0_accesses;
  reg trap_shared_regs;
  reg maint_on_g1_off;
  reg maint_on_g1_on;
  reg maint_on_g0_off;
  reg maint_on_g0_on;
  reg maint_on_nothing_pending;
  reg maint_on_missing_entry;
  reg maint_on_list_underflow;
  reg hcr_enable;
  reg [7:0] pmr;
  reg split_eoi;
  reg shared_bp;
  reg g0_on;
  reg g1_on;
  wire [2:0] bp0;
  wire [2:0] bp1;

  wire [`VIHC_ENC_W-1:0] enc;
  wire sel_ap1r;
  wire sel_hcr;
  wire sel_vtr;
  wire sel_vmcr;
  wire mapped;
  wire hyp_wr;
  wire [31:0] hcr_view;
  wire [31:0] vmcr_view;
  wire [2:0] bp1_read;

  reg [31:0] next_map;
  reg [31:0] drop_mask;
  reg [4:0] next_count;
  reg g_trap;
  reg g_wr;
  reg [31:0] g_read;
  reg maint_cond;
  reg [3:0] valid_count;
  integer i, j;

  assign enc = {sysreg_op0, sysreg_op1, sysreg_crn, sysreg_crm, sysreg_op2};
  assign sel_ap1r = (enc == `VIHC_ENC_AP1R);
  assign sel_hcr = (enc == `VIHC_ENC_HCR);
  assign sel_vtr = (enc == `VIHC_ENC_VTR);
  assign sel_vmcr = (enc == `VIHC_ENC_VMCR);
  assign mapped = sel_ap1r | sel_hcr | sel_vtr | sel_vmcr;
  assign hyp_wr = ce & sysreg_valid & sysreg_write;

  // Bit 13 and reserved bits are constant zero in the read view
  assign hcr_view = {pending_deactivate_count, 12'h000, trap_deactivate_writes, 1'b0, // [R3] [R5] [R25]
                     trap_grp1_accesses, trap_grp0_accesses, trap_shared_regs, 2'b00,
                     maint_on_g1_off, maint_on_g1_on, maint_on_g0_off, maint_on_g0_on,
                     maint_on_nothing_pending, maint_on_missing_entry, maint_on_list_underflow,
                     hcr_enable};

  // Single storage shared by hypervisor and guest views
  assign vmcr_view = {pmr, bp0, bp1, 8'h00, split_eoi, 4'h0, shared_bp, 1'b1, 1'b0, // [R14] [R19] [R25]
                      g1_on, g0_on};

  // Shared point: Group 1 view follows Group 0 plus one, saturated
  assign bp1_read = shared_bp ? ((bp0 == `VIHC_BP_MAX) ? `VIHC_BP_MAX : bp0 + 3'h1) : bp1; // [R18]

  // Guest access decode and trap classification
  always @* begin
    g_trap = 1'b0;
    g_wr = 1'b0;
    g_read = 32'h0000_0000;
    case (guest_sel)
      `VIHC_G_PMR: begin
        g_trap = trap_shared_regs; // [R8]
        g_read = {24'h00_0000, pmr}; // [R14]
      end
      `VIHC_G_BP0: begin
        g_trap = trap_grp0_accesses; // [R7]
        g_read = {29'h0000_0000, bp0}; // [R15]
      end
      `VIHC_G_BP1: begin
        g_trap = trap_grp1_accesses; // [R6]
        g_read = {29'h0000_0000, bp1_read}; // [R16] [R18]
      end
      `VIHC_G_CTLR: begin
        g_trap = trap_shared_regs; // [R8]
        g_read = `VIHC_CTLR_RO | {30'h0000_0000, split_eoi, shared_bp}; // [R17]
      end
      `VIHC_G_EN0: begin
        g_trap = trap_grp0_accesses; // [R7]
        g_read = {31'h0000_0000, g0_on}; // [R20]
      end
      `VIHC_G_EN1: begin
        g_trap = trap_grp1_accesses; // [R6]
        g_read = {31'h0000_0000, g1_on}; // [R20]
      end
      `VIHC_G_DIR: begin
        g_trap = trap_shared_regs | (guest_write & trap_deactivate_writes); // [R4] [R8]
        g_read = 32'h0000_0000;
      end
      default: begin
        g_trap = 1'b0;
        g_read = 32'h0000_0000;
      end
    endcase
    g_trap = g_trap & guest_ns_el1;
    g_wr = ce & guest_valid & guest_write & ~g_trap;
  end

  // Active priorities: drop clears lowest set bit, activation wins on same bit
  always @* begin
    drop_mask = 32'h0000_0000;
    for (i = 31; i >= 0; i = i - 1) begin
      if (group1_active_priority_map[i]) begin
        drop_mask = 32'h0000_0000;
        drop_mask[i] = 1'b1;
      end
    end
    next_map = group1_active_priority_map;
    if (prio_drop) begin
      next_map = next_map & ~drop_mask;
    end
    if (hyp_wr && sel_ap1r) begin
      next_map = sysreg_wdata;
    end
    if (prio_activate) begin
      next_map[prio_activate_level[7:3]] = 1'b1; // [R1]
    end
  end

  // Outstanding count: hardware events apply on top of a software write
  always @* begin
    next_count = pending_deactivate_count;
    if (hyp_wr && sel_hcr) begin
      next_count = sysreg_wdata[`VIHC_HCR_CNT_HI:`VIHC_HCR_CNT_LO]; // [R3]
    end
    if (deactivate_miss && !deactivate_done && next_count != `VIHC_CNT_MAX) begin
      next_count = next_count + 5'h01;
    end else if (deactivate_done && !deactivate_miss && next_count != 5'h00) begin
      next_count = next_count - 5'h01;
    end
  end

  // Valid entry count for the underflow condition
  always @* begin
    valid_count = 4'h0;
    for (j = 0; j < LIST_ENTRIES; j = j + 1) begin
      valid_count = valid_count + {3'h0, lr_valid[j]};
    end
  end

  always @* begin
    maint_cond = (maint_on_g1_off & ~g1_on) | (maint_on_g1_on & g1_on) // [R9]
               | (maint_on_g0_off & ~g0_on) | (maint_on_g0_on & g0_on) // [R9]
               | (maint_on_nothing_pending & ~(|lr_pending)) // [R10]
               | (maint_on_missing_entry & (pending_deactivate_count != 5'h00)) // [R11]
               | (maint_on_list_underflow & (valid_count <= 4'h1)); // [R12]
  end

  vihc_bp_field #(
    .MIN_VALUE(`VIHC_BP0_MIN)
  ) u_bp0 (
    .clock(clock),
    .reset(reset),
    .ce(ce),
    .wr((hyp_wr & sel_vmcr) | (g_wr & (guest_sel == `VIHC_G_BP0))), // [R15]
    .wdata((hyp_wr & sel_vmcr) ? sysreg_wdata[`VIHC_VM_BP0_HI:`VIHC_VM_BP0_LO] : guest_wdata[2:0]),
    .value(bp0)
  );

  // Guest writes to the Group 1 point are dropped while the point is shared
  vihc_bp_field #(
    .MIN_VALUE(`VIHC_BP1_MIN)
  ) u_bp1 (
    .clock(clock),
    .reset(reset),
    .ce(ce),
    .wr((hyp_wr & sel_vmcr) | (g_wr & (guest_sel == `VIHC_G_BP1) & ~shared_bp)), // [R16] [R18]
    .wdata((hyp_wr & sel_vmcr) ? sysreg_wdata[`VIHC_VM_BP1_HI:`VIHC_VM_BP1_LO] : guest_wdata[2:0]),
    .value(bp1)
  );

  // Register state
  always @(posedge clock) begin
    if (reset) begin
      group1_active_priority_map <= `VIHC_AP1R_RST; // [R2]
      pending_deactivate_count <= 5'h00;
      trap_deactivate_writes <= 1'b0;
      trap_grp1_accesses <= 1'b0;
      trap_grp0_accesses <= 1'b0;
      trap_shared_regs <= 1'b0;
      maint_on_g1_off <= 1'b0;
      maint_on_g1_on <= 1'b0;
      maint_on_g0_off <= 1'b0;
      maint_on_g0_on <= 1'b0;
      maint_on_nothing_pending <= 1'b0;
      maint_on_missing_entry <= 1'b0;
      maint_on_list_underflow <= 1'b0;
      hcr_enable <= 1'b0;
      pmr <= `VIHC_PMR_RST;
      split_eoi <= 1'b0;
      shared_bp <= 1'b0;
      g0_on <= 1'b0;
      g1_on <= 1'b0;
    end else if (ce) begin
      group1_active_priority_map <= next_map; // [R1] [R24]
      pending_deactivate_count <= next_count; // [R3]
      if (hyp_wr && sel_hcr) begin
        trap_deactivate_writes <= sysreg_wdata[`VIHC_HCR_TRAP_DEACTIVATE_WRITES]; // [R4]
        trap_grp1_accesses <= sysreg_wdata[`VIHC_HCR_TRAP_GRP1_ACCESSES]; // [R6]
        trap_grp0_accesses <= sysreg_wdata[`VIHC_HCR_TRAP_GRP0_ACCESSES]; // [R7]
        trap_shared_regs <= sysreg_wdata[`VIHC_HCR_TC]; // [R8]
        maint_on_g1_off <= sysreg_wdata[`VIHC_HCR_G1OFF]; // [R9]
        maint_on_g1_on <= sysreg_wdata[`VIHC_HCR_G1ON];
        maint_on_g0_off <= sysreg_wdata[`VIHC_HCR_G0OFF];
        maint_on_g0_on <= sysreg_wdata[`VIHC_HCR_G0ON];
        maint_on_nothing_pending <= sysreg_wdata[`VIHC_HCR_MAINT_ON_NOTHING_PENDING]; // [R10]
        maint_on_missing_entry <= sysreg_wdata[`VIHC_HCR_LRENP]; // [R11]
        maint_on_list_underflow <= sysreg_wdata[`VIHC_HCR_UIE]; // [R12]
        hcr_enable <= sysreg_wdata[`VIHC_HCR_EN]; // [R13]
      end
      if (hyp_wr && sel_vmcr) begin
        pmr <= sysreg_wdata[`VIHC_VM_PMR_HI:`VIHC_VM_PMR_LO]; // [R14]
        split_eoi <= sysreg_wdata[`VIHC_VM_EOIM]; // [R17]
        shared_bp <= sysreg_wdata[`VIHC_VM_CBPR]; // [R18]
        g1_on <= sysreg_wdata[`VIHC_VM_ENG1]; // [R20]
        g0_on <= sysreg_wdata[`VIHC_VM_ENG0]; // [R20]
      end else if (g_wr) begin
        if (guest_sel == `VIHC_G_PMR) begin
          pmr <= guest_wdata[7:0]; // [R14]
        end
        if (guest_sel == `VIHC_G_CTLR) begin
          split_eoi <= guest_wdata[1]; // [R17]
          shared_bp <= guest_wdata[0];
        end
        if (guest_sel == `VIHC_G_EN0) begin
          g0_on <= guest_wdata[0]; // [R20]
        end
        if (guest_sel == `VIHC_G_EN1) begin
          g1_on <= guest_wdata[0]; // [R20]
        end
      end
    end
  end

  // Hypervisor answers, one cycle after the request
  always @(posedge clock) begin
    if (reset) begin
      sysreg_ack <= 1'b0;
      sysreg_undefined <= 1'b0;
      sysreg_rdata <= 32'h0000_0000;
      lr_access_undefined <= 1'b0;
    end else if (ce) begin
      sysreg_ack <= sysreg_valid;
      sysreg_undefined <= sysreg_valid & ~mapped;
      lr_access_undefined <= lr_access_valid & (lr_access_index > `VIHC_LR_LAST); // [R23]
      if (sysreg_valid && !sysreg_write) begin
        if (sel_ap1r) begin
          sysreg_rdata <= group1_active_priority_map;
        end else if (sel_hcr) begin
          sysreg_rdata <= hcr_view;
        end else if (sel_vtr) begin
          // Writes here fall through with no storage to change
          sysreg_rdata <= `VIHC_VTR_VAL; // [R21] [R22] [R23] [R24]
        end else if (sel_vmcr) begin
          sysreg_rdata <= vmcr_view;
        end else begin
          sysreg_rdata <= 32'h0000_0000;
        end
      end else begin
        sysreg_rdata <= 32'h0000_0000;
      end
    end
  end

  // Guest answers and state outputs
  always @(posedge clock) begin
    if (reset) begin
      guest_ack <= 1'b0;
      guest_trap <= 1'b0;
      guest_rdata <= 32'h0000_0000;
      phys_deactivate_trap <= 1'b0;
      maint_irq <= 1'b0;
      vif_enabled <= 1'b0;
      error_irq_trap <= 1'b0;
      g0_as_fast_irq <= 1'b1;
      guest_split_eoi_mode <= 1'b0;
      guest_g0_on <= 1'b0;
      guest_g1_on <= 1'b0;
      guest_shared_binary_point <= 1'b0;
      guest_priority_mask <= `VIHC_PMR_RST;
      active_map <= `VIHC_AP1R_RST;
    end else if (ce) begin
      guest_ack <= guest_valid;
      guest_trap <= guest_valid & g_trap; // [R4] [R6] [R7] [R8]
      guest_rdata <= (guest_valid && !guest_write && !g_trap) ? g_read : 32'h0000_0000;
      phys_deactivate_trap <= phys_deactivate_write & guest_ns_el1 & trap_deactivate_writes; // [R4]
      // Maintenance is only meaningful while the interface runs
      maint_irq <= hcr_enable & maint_cond; // [R9] [R13]
      vif_enabled <= hcr_enable; // [R13]
      error_irq_trap <= local_error_irq & 1'b0; // [R5]
      g0_as_fast_irq <= 1'b1; // [R19]
      guest_split_eoi_mode <= split_eoi; // [R17]
      guest_g0_on <= g0_on; // [R20]
      guest_g1_on <= g1_on; // [R20]
      guest_shared_binary_point <= shared_bp;
      guest_priority_mask <= pmr;
      active_map <= group1_active_priority_map;
    end
  end

endmodule

`default_nettype wire

// >>> bench/vihc_top_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "vihc_consts.vh"

module vihc_top_monitor (
  input wire logic clock,
  input wire logic reset,
  input wire logic ce,
  input wire logic sysreg_valid,
  input wire logic sysreg_write,
  input wire logic [1:0] sysreg_op0,
  input wire logic [2:0] sysreg_op1,
  input wire logic [4:0] sysreg_crn,
  input wire logic [3:0] sysreg_crm,
  input wire logic [2:0] sysreg_op2,
  input wire logic sysreg_ack,
  input wire logic sysreg_undefined,
  input wire logic [31:0] sysreg_rdata,
  input wire logic lr_access_valid,
  input wire logic [3:0] lr_access_index,
  input wire logic lr_access_undefined,
  input wire logic guest_valid,
  input wire logic guest_ack,
  input wire logic guest_trap,
  input wire logic prio_activate,
  input wire logic [7:0] prio_activate_level,
  input wire logic prio_drop,
  input wire logic maint_irq,
  input wire logic vif_enabled,
  input wire logic error_irq_trap,
  input wire logic g0_as_fast_irq,
  input wire logic [31:0] active_map
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  a_sys_ack_timing: assert property (ce && sysreg_valid |=> sysreg_ack)
    else $error("register access not answered in one cycle");
  a_type_value: assert property (ce && sysreg_valid && !sysreg_write &&
    {sysreg_op0, sysreg_op1, sysreg_crn, sysreg_crm, sysreg_op2} == `VIHC_ENC_VTR
    |=> sysreg_rdata == 32'h9028_0003 && !sysreg_undefined)
    else $error("type register value wrong");
  a_fast_fixed: assert property (g0_as_fast_irq)
    else $error("group 0 fast presentation dropped");
  a_no_error_trap: assert property (!error_irq_trap)
    else $error("local error interrupt trapped");
  a_list_undef: assert property (ce && lr_access_valid |=>
    lr_access_undefined == ($past(lr_access_index) > 4'h3))
    else $error("list entry undefined flag wrong");
  a_maint_gated: assert property (maint_irq |-> vif_enabled)
    else $error("maintenance while interface off");
  a_map_clear: assert property ($fell(reset) |-> active_map == 32'h0000_0000)
    else $error("active map not clear after reset");
  a_trap_with_ack: assert property (guest_trap |-> guest_ack)
    else $error("trap without answer");
  a_guest_ack: assert property (ce && guest_valid |=> guest_ack)
    else $error("guest access not answered");
  a_map_sets_bit: assert property (ce && prio_activate ##1 ce && !prio_drop && !sysreg_valid
    |=> active_map[$past(prio_activate_level, 2) >> 3])
    else $error("activation bit not set");
endmodule

`default_nettype wire

// >>> bench/vihc_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "vihc_consts.vh"

module vihc_top_tb;
  logic clock = 1'b0, reset = 1'b1, ce = 1'b1, sysreg_valid = 1'b0, sysreg_write = 1'b0;
  logic lr_access_valid = 1'b0, guest_valid = 1'b0, guest_write = 1'b0, guest_ns_el1 = 1'b0;
  logic phys_deactivate_write = 1'b0, prio_activate = 1'b0, prio_drop = 1'b0;
  logic deactivate_miss = 1'b0, deactivate_done = 1'b0, local_error_irq = 1'b0;
  logic [1:0] sysreg_op0 = 2'h0;
  logic [2:0] sysreg_op1 = 3'h0, sysreg_op2 = 3'h0, guest_sel = 3'h0;
  logic [4:0] sysreg_crn = 5'h00;
  logic [3:0] sysreg_crm = 4'h0, lr_access_index = 4'h0, lr_valid = 4'hf, lr_pending = 4'hf;
  logic [7:0] prio_activate_level = 8'h00;
  logic [31:0] sysreg_wdata = 32'h0000_0000, guest_wdata = 32'h0000_0000;
  logic sysreg_ack, sysreg_undefined, lr_access_undefined, guest_ack, guest_trap, phys_deactivate_trap;
  logic maint_irq, vif_enabled, error_irq_trap, g0_as_fast_irq, guest_split_eoi_mode, guest_g0_on;
  logic guest_g1_on, guest_shared_binary_point, ud, tr;
  logic [7:0] guest_priority_mask;
  logic [31:0] sysreg_rdata, guest_rdata, active_map, rd;
  int err_total = 0, compares = 0, b, v, k, s;
  // Selectors trapped by control bits 10, 11, 12
  logic [6:0] tmask [3] = '{7'h49, 7'h12, 7'h24};

  vihc_top uut (.*);

  task automatic conclude;
    $display("compares %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask

  task automatic tmo(input int n);
    if (n == 4) begin
      err_total++;
      $display("unexpected at %0t: no answer", $time);
      conclude();
    end
  endtask

  task automatic hv(input logic w, input logic [16:0] e, input logic [31:0] d);
    int n;
    @(posedge clock);
    sysreg_valid <= 1'b1;
    sysreg_write <= w;
    {sysreg_op0, sysreg_op1, sysreg_crn, sysreg_crm, sysreg_op2} <= e;
    sysreg_wdata <= d;
    @(posedge clock);
    sysreg_valid <= 1'b0;
    #1;
    for (n = 0; n < 4 && sysreg_ack !== 1'b1; n++) @(posedge clock) #1;
    tmo(n);
    rd = sysreg_rdata;
    ud = sysreg_undefined;
  endtask

  task automatic gs(input logic w, input logic ns, input logic [2:0] sel, input logic [31:0] d);
    int n;
    @(posedge clock);
    guest_valid <= 1'b1;
    guest_write <= w;
    guest_ns_el1 <= ns;
    guest_sel <= sel;
    guest_wdata <= d;
    @(posedge clock);
    guest_valid <= 1'b0;
    #1;
    for (n = 0; n < 4 && guest_ack !== 1'b1; n++) @(posedge clock) #1;
    tmo(n);
    rd = guest_rdata;
    tr = guest_trap;
  endtask

  // Maintenance is a registered level, so allow two edges to settle
  task automatic mw(input logic e);
    repeat (2) @(posedge clock);
    #1;
    chk(32'(maint_irq), 32'(e));
  endtask

  task automatic ev(input logic [3:0] m, input logic [7:0] lv);
    @(posedge clock);
    {prio_activate, prio_drop, deactivate_miss, deactivate_done} <= m;
    prio_activate_level <= lv;
    @(posedge clock);
    {prio_activate, prio_drop, deactivate_miss, deactivate_done} <= 4'h0;
  endtask

  initial forever #4 clock = ~clock;

  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    hv(0, `VIHC_ENC_AP1R, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    hv(0, `VIHC_ENC_VMCR, 32'h0000_0000);
    chk(rd, 32'h004c_0008);
    hv(1, `VIHC_ENC_VTR, 32'hffff_ffff);
    hv(0, `VIHC_ENC_VTR, 32'h0000_0000);
    chk(rd, 32'h9028_0003);
    hv(0, 17'h0_0000, 32'h0000_0000);
    chk({rd[30:0], ud}, 32'h0000_0001);
    $display("reset values test finished");
    local_error_irq <= 1'b1;
    hv(1, `VIHC_ENC_HCR, 32'hffff_ffff);
    hv(0, `VIHC_ENC_HCR, 32'h0000_0000);
    chk(rd, 32'hf800_5cff);
    hv(1, `VIHC_ENC_HCR, 32'h0000_0005);
    mw(1'b0);
    ev(4'h2, 8'h00);
    mw(1'b1);
    ev(4'h3, 8'h00);
    hv(0, `VIHC_ENC_HCR, 32'h0000_0000);
    chk(rd, 32'h0800_0005);
    ev(4'h1, 8'h00);
    mw(1'b0);
    ev(4'h1, 8'h00);
    hv(0, `VIHC_ENC_HCR, 32'h0000_0000);
    chk(rd, 32'h0000_0005);
    hv(1, `VIHC_ENC_HCR, 32'hf800_0005);
    ev(4'h2, 8'h00);
    hv(0, `VIHC_ENC_HCR, 32'h0000_0000);
    chk(rd, 32'hf800_0005);
    hv(1, `VIHC_ENC_HCR, 32'h0000_0009);
    mw(1'b0);
    @(posedge clock) lr_pending <= 4'h0;
    mw(1'b1);
    @(posedge clock) lr_pending <= 4'h4;
    mw(1'b0);
    hv(1, `VIHC_ENC_HCR, 32'h0000_0003);
    @(posedge clock) lr_valid <= 4'h1;
    mw(1'b1);
    @(posedge clock) lr_valid <= 4'h3;
    mw(1'b0);
    @(posedge clock) lr_valid <= 4'h0;
    mw(1'b1);
    hv(1, `VIHC_ENC_HCR, 32'h0000_0002);
    mw(1'b0);
    chk(32'(vif_enabled), 32'h0000_0000);
    @(posedge clock) lr_valid <= 4'hf;
    // Only the enable of the bit's own group moves, so a group swap shows
    for (b = 4; b < 8; b++) begin
      for (v = 0; v < 2; v++) begin
        hv(1, `VIHC_ENC_VMCR, 32'(v << (b > 5 ? 1 : 0)));
        hv(1, `VIHC_ENC_HCR, 32'(1 << b) | 32'h0000_0001);
        mw((b % 2 == 0) == (v == 1));
      end
    end
    $display("control test finished");
    hv(1, `VIHC_ENC_VMCR, 32'hffff_ffff);
    hv(0, `VIHC_ENC_VMCR, 32'h0000_0000);
    chk(rd, 32'hfffc_021b);
    gs(0, 1'b0, `VIHC_G_PMR, 32'h0000_0000);
    chk(rd, 32'h0000_00ff);
    gs(1, 1'b0, `VIHC_G_PMR, 32'h0000_005a);
    chk(32'({guest_split_eoi_mode, guest_shared_binary_point, guest_g1_on, guest_g0_on}), 32'hf);
    gs(1, 1'b0, `VIHC_G_BP0, 32'h0000_0006);
    gs(0, 1'b0, `VIHC_G_BP1, 32'h0000_0000);
    chk(rd, 32'h0000_0007);
    gs(1, 1'b0, `VIHC_G_BP0, 32'h0000_0003);
    gs(0, 1'b0, `VIHC_G_BP1, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    gs(1, 1'b0, `VIHC_G_BP1, 32'h0000_0005);
    gs(1, 1'b0, `VIHC_G_BP0, 32'h0000_0000);
    hv(0, `VIHC_ENC_VMCR, 32'h0000_0000);
    chk(rd, 32'h5a5c_021b);
    chk(32'(guest_priority_mask), 32'h0000_005a);
    gs(0, 1'b0, `VIHC_G_CTLR, 32'h0000_0000);
    chk(rd, 32'h0000_8403);
    gs(1, 1'b0, `VIHC_G_CTLR, 32'h0000_0002);
    gs(1, 1'b0, `VIHC_G_EN0, 32'h0000_0000);
    hv(0, `VIHC_ENC_VMCR, 32'h0000_0000);
    chk(rd, 32'h5a5c_020a);
    chk(32'({guest_split_eoi_mode, guest_shared_binary_point, guest_g1_on, guest_g0_on}), 32'ha);
    hv(1, `VIHC_ENC_VMCR, 32'h0000_0000);
    hv(0, `VIHC_ENC_VMCR, 32'h0000_0000);
    chk(rd, 32'h004c_0008);
    $display("guest state test finished");
    for (k = 0; k < 3; k++) begin
      hv(1, `VIHC_ENC_HCR, 32'(1 << (10 + k)));
      for (s = 0; s < 7; s++) begin
        gs(0, 1'b1, 3'(s), 32'h0000_0000);
        chk(32'(tr), 32'(tmask[k][s]));
      end
    end
    hv(1, `VIHC_ENC_HCR, 32'h0000_5c00);
    gs(0, 1'b0, `VIHC_G_EN1, 32'h0000_0000);
    chk(32'(tr), 32'h0000_0000);
    gs(1, 1'b1, `VIHC_G_PMR, 32'h0000_0033);
    hv(0, `VIHC_ENC_VMCR, 32'h0000_0000);
    chk(rd, 32'h004c_0008);
    for (v = 0; v < 2; v++) begin
      hv(1, `VIHC_ENC_HCR, 32'(v << 14));
      gs(1, 1'b1, `VIHC_G_DIR, 32'h0000_0000);
      chk(32'(tr), 32'(v));
      @(posedge clock) phys_deactivate_write <= 1'b1;
      @(posedge clock) phys_deactivate_write <= 1'b0;
      #1;
      chk(32'(phys_deactivate_trap), 32'(v));
    end
    $display("trap test finished");
    ev(4'h8, 8'h00);
    ev(4'h8, 8'hf8);
    ev(4'h8, 8'h0f);
    hv(0, `VIHC_ENC_AP1R, 32'h0000_0000);
    chk(rd, 32'h8000_0003);
    ev(4'h4, 8'h00);
    hv(0, `VIHC_ENC_AP1R, 32'h0000_0000);
    chk(rd, 32'h8000_0002);
    chk(active_map, 32'h8000_0002);
    // A frozen enable must swallow this activation
    @(posedge clock) ce <= 1'b0;
    ev(4'h8, 8'h40);
    @(posedge clock) ce <= 1'b1;
    hv(0, `VIHC_ENC_AP1R, 32'h0000_0000);
    chk(rd, 32'h8000_0002);
    hv(1, `VIHC_ENC_AP1R, 32'h1234_5678);
    hv(0, `VIHC_ENC_AP1R, 32'h0000_0000);
    chk(rd, 32'h1234_5678);
    for (s = 0; s < 16; s++) begin
      @(posedge clock);
      lr_access_valid <= 1'b1;
      lr_access_index <= 4'(s);
      @(posedge clock);
      lr_access_valid <= 1'b0;
      #1;
      chk(32'(lr_access_undefined), 32'(s > 3));
    end
    @(posedge clock) reset <= 1'b1;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    hv(0, `VIHC_ENC_AP1R, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(active_map, 32'h0000_0000);
    $display("map and list test finished");
    conclude();
  end
endmodule

bind vihc_top vihc_top_monitor mon (.*);

`default_nettype wire
